//--- hw/lrs_pkg.sv
// lrs_pkg: constants and carriers for the locality request and command status block.
// assumes a single 200 MHz clock domain and a plain strobe register port.
package lrs_pkg;

    // ****************************************
    // geometry and register map
    // ****************************************
    localparam int NUM_LOC = 5;
    localparam int LOC_W = 3;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    // each locality owns a 4 KiB page; register offset within the page
    localparam int LOC_SHIFT = 12;
    localparam logic [11:0] OFF_ACCESS = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h018;
    localparam logic [11:0] OFF_FIFO = 12'h024;

    // ****************************************
    // access register fields
    // ****************************************
    localparam int ACC_VALID = 7;
    localparam int ACC_GRANTED = 5;
    localparam int ACC_WAITING = 2;
    localparam int ACC_REQUEST = 1;
    localparam int ACC_ESTAB = 0;

    // ****************************************
    // status register fields
    // ****************************************
    localparam int STS_CLR_ESTAB = 25;
    localparam int STS_STS_VALID = 7;
    localparam int STS_CMD_READY = 6;
    localparam int STS_EXECUTE = 5;
    localparam int STS_RESP_AVAIL = 4;
    localparam logic [DATA_W-1:0] STS_WRITABLE = 32'h0200_0060;

    // localities allowed to clear the established flag
    localparam logic [LOC_W-1:0] LOC_THREE = 3'h3;
    localparam logic [LOC_W-1:0] LOC_FOUR = 3'h4;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int GRANT_TIMEOUT_US = 750;
    localparam int GRANT_TIMEOUT_CYC = (GRANT_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
    localparam int EXEC_CYC_DEFAULT = 16;
    localparam int CNT_W = 20;

    typedef enum logic [2:0] {
        LRS_IDLE,
        LRS_READY,
        LRS_RECEIVE,
        LRS_EXECUTE,
        LRS_COMPLETE
    } lrs_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lrs_bus_t;

    // one decoded write, split by locality and register
    typedef struct packed {
        logic access_wr;
        logic status_wr;
        logic fifo_wr;
        logic [LOC_W-1:0] loc;
        logic [DATA_W-1:0] data;
    } lrs_wreq_t;

endpackage : lrs_pkg

//--- hw/lrs_decode.sv
// lrs_decode: splits a register port write into locality, register and data.
// assumes address bits above the locality page field are already filtered.
`timescale 1ns/1ps
module lrs_decode (
    input wire lrs_pkg::lrs_bus_t bus_in,
    output lrs_pkg::lrs_wreq_t wreq_out,
    output logic [lrs_pkg::LOC_W-1:0] loc_out,
    output logic loc_ok_out
);
    logic [11:0] off;

    always_comb begin
        off = bus_in.addr[11:0];
        loc_out = bus_in.addr[lrs_pkg::LOC_SHIFT +: lrs_pkg::LOC_W];
        loc_ok_out = (32'(loc_out) < lrs_pkg::NUM_LOC);
        wreq_out.loc = loc_out;
        wreq_out.data = bus_in.wdata;
        wreq_out.access_wr = bus_in.wr && loc_ok_out && (off == lrs_pkg::OFF_ACCESS);
        wreq_out.status_wr = bus_in.wr && loc_ok_out && (off == lrs_pkg::OFF_STATUS);
        wreq_out.fifo_wr = bus_in.wr && loc_ok_out && (off == lrs_pkg::OFF_FIFO);
    end
endmodule : lrs_decode

//--- hw/lrs_grant_timer.sv
// lrs_grant_timer: counts cycles while a deadline is pending, flags expiry.
// assumes run_in is a level that stays high while the wait lasts.
`timescale 1ns/1ps
module lrs_grant_timer #(
    parameter int LIMIT = lrs_pkg::GRANT_TIMEOUT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    output logic expired_out
);
    logic [lrs_pkg::CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
        end else if (!run_in) begin
            cnt_reg <= '0;
        end else if (32'(cnt_reg) < LIMIT) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign expired_out = (32'(cnt_reg) >= LIMIT);
endmodule : lrs_grant_timer

//--- hw/lrs_locality_status.sv
// lrs_locality_status: locality request/grant fields, launch established flag and the
// command status state machine behind a per-locality register page.
// assumes a strobe register port with read data one cycle later, and a nonvolatile
// cell outside that holds the established flag across power and reset.
// Contract
// - a write of one to request sets only the writing locality's request flag.
// - a repeated write of one to a set request flag changes nothing.
// - request flag clears when that locality is granted.
// - a granted-field write of one from a waiting locality cancels its request.
// - writes of zero to request never clear it.
// - while access valid reads one, established reads its true value.
// - while access valid reads zero, established never reads a false one.
// - launch hash finish clears a set established flag within grant timeout.
// - a cleared established flag stays zero until a clear command write.
// - a zero established flag survives power and reset via nonvolatile cell.
// - one established flag, identical in every locality's access register.
// - status writes with more than one set field are discarded whole.
// - status fields written as zero cause no action.
// - reception runs from first fifo byte after ready until execute write.
// - execution runs from execute until response available, unless aborted.
// - completion runs from response available until a command-ready write.
// - idle follows completion plus ready write, locality change, abort, init; here a ready write in completion goes straight to ready.
// - ready write prepares in idle, aborts in execution, frees after completion.
// - the first ready write after completion also makes the device ready.
// - with no locality active, a request is granted within the grant timeout.
// - a request sets the waiting indication for every other locality.
// - clear-established command acts only from locality three or four.
`timescale 1ns/1ps
module lrs_locality_status #(
    parameter int NUM_LOC = lrs_pkg::NUM_LOC,
    parameter int EXEC_CYC = lrs_pkg::EXEC_CYC_DEFAULT
) (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic INIT_IN,
    input wire logic [lrs_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [lrs_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [lrs_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic HASH_FINISH_IN,
    input wire logic NV_ESTAB_IN,
    input wire logic NV_VALID_IN,
    output logic NV_WRITE_OUT,
    output logic NV_ESTAB_OUT,
    output logic [lrs_pkg::LOC_W-1:0] ACTIVE_LOC_OUT,
    output logic ACTIVE_VALID_OUT,
    output lrs_pkg::lrs_state_t STATE_OUT
);

    // ****************************************
    // decode
    // ****************************************
    lrs_pkg::lrs_bus_t bus;
    lrs_pkg::lrs_wreq_t wreq;
    logic [lrs_pkg::LOC_W-1:0] rd_loc;
    logic rd_loc_ok;

    assign bus.wr = WR_IN;
    assign bus.rd = RD_IN;
    assign bus.addr = ADDR_IN;
    assign bus.wdata = WDATA_IN;

    lrs_decode u_decode (
        .bus_in(bus),
        .wreq_out(wreq),
        .loc_out(rd_loc),
        .loc_ok_out(rd_loc_ok)
    );

    function automatic logic one_hot_or_zero(input logic [lrs_pkg::DATA_W-1:0] v);
        return ((v & (v - 32'h0000_0001)) == 32'h0000_0000);
    endfunction : one_hot_or_zero

    // ****************************************
    // locality request and grant
    // ****************************************
    logic [NUM_LOC-1:0] request_reg;
    logic [NUM_LOC-1:0] waiting_reg;
    logic [lrs_pkg::LOC_W-1:0] active_loc_reg;
    logic active_valid_reg;
    logic [NUM_LOC-1:0] wr_loc_onehot;
    logic acc_req_wr;
    logic acc_rel_wr;
    logic rel_by_active;
    logic cancel_wr;
    logic grant_now;
    logic [lrs_pkg::LOC_W-1:0] grant_loc;
    logic [NUM_LOC-1:0] request_next;
    logic [NUM_LOC-1:0] waiting_next;

    always_comb begin
        wr_loc_onehot = '0;
        wr_loc_onehot[wreq.loc] = 1'b1;
    end

    assign acc_req_wr = wreq.access_wr && wreq.data[lrs_pkg::ACC_REQUEST];
    assign acc_rel_wr = wreq.access_wr && wreq.data[lrs_pkg::ACC_GRANTED];
    assign rel_by_active = acc_rel_wr && active_valid_reg && (wreq.loc == active_loc_reg);
    assign cancel_wr = acc_rel_wr && !rel_by_active && request_reg[wreq.loc];

    // highest-numbered pending locality wins; grant happens the cycle after it is free
    always_comb begin
        grant_now = 1'b0;
        grant_loc = '0;
        for (int i = 0; i < NUM_LOC; i++) begin
            if (request_reg[i]) begin
                grant_now = !active_valid_reg;
                grant_loc = lrs_pkg::LOC_W'(i);
            end
        end
    end

    always_comb begin
        request_next = request_reg;
        if (grant_now) begin
            request_next[grant_loc] = 1'b0;
        end
        if (cancel_wr) begin
            request_next[wreq.loc] = 1'b0;
        end
        // zero writes fall through untouched, and a held one is simply kept
        if (acc_req_wr && !request_reg[wreq.loc] && !(active_valid_reg && wreq.loc == active_loc_reg)) begin
            request_next[wreq.loc] = 1'b1;
        end
        waiting_next = '0;
        for (int i = 0; i < NUM_LOC; i++) begin
            waiting_next = waiting_next | (request_next[i] ? ~(NUM_LOC'(1) << i) : '0);
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            request_reg <= '0;
            waiting_reg <= '0;
        end else if (INIT_IN) begin
            request_reg <= '0;
            waiting_reg <= '0;
        end else begin
            request_reg <= request_next;
            waiting_reg <= waiting_next;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            active_valid_reg <= 1'b0;
            active_loc_reg <= '0;
        end else if (INIT_IN) begin
            active_valid_reg <= 1'b0;
            active_loc_reg <= '0;
        end else if (grant_now) begin
            active_valid_reg <= 1'b1;
            active_loc_reg <= grant_loc;
        end else if (rel_by_active) begin
            active_valid_reg <= 1'b0;
        end
    end

    // ****************************************
    // launch established flag
    // ****************************************
    // the live copy mirrors the nonvolatile cell; until that cell reports valid the
    // flag reads zero, which is always a permitted answer
    logic estab_reg;
    logic estab_loaded_reg;
    logic hash_pending_reg;
    logic hash_expired;
    logic sts_ok;
    logic clear_estab;

    assign sts_ok = wreq.status_wr && one_hot_or_zero(wreq.data & lrs_pkg::STS_WRITABLE);
    assign clear_estab = sts_ok && wreq.data[lrs_pkg::STS_CLR_ESTAB]
        && (wreq.loc == lrs_pkg::LOC_THREE || wreq.loc == lrs_pkg::LOC_FOUR);

    lrs_grant_timer #(
        .LIMIT(lrs_pkg::GRANT_TIMEOUT_CYC)
    ) u_hash_timer (
        .clk_in(CLOCK_IN),
        .rst_in(RESET_IN),
        .run_in(hash_pending_reg),
        .expired_out(hash_expired)
    );

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            estab_loaded_reg <= 1'b0;
        end else if (NV_VALID_IN) begin
            estab_loaded_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            estab_reg <= 1'b0;
            hash_pending_reg <= 1'b0;
        end else if (!estab_loaded_reg) begin
            estab_reg <= NV_VALID_IN ? NV_ESTAB_IN : 1'b0;
            hash_pending_reg <= 1'b0;
        end else if (HASH_FINISH_IN && estab_reg) begin
            estab_reg <= 1'b0;
            hash_pending_reg <= 1'b1;
        end else if (clear_estab) begin
            estab_reg <= 1'b1;
            hash_pending_reg <= 1'b0;
        end else if (hash_expired) begin
            hash_pending_reg <= 1'b0;
        end
    end

    // nonvolatile write-back on each change of the live copy
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            NV_WRITE_OUT <= 1'b0;
            NV_ESTAB_OUT <= 1'b1;
        end else begin
            NV_WRITE_OUT <= estab_loaded_reg && ((HASH_FINISH_IN && estab_reg) || clear_estab);
            NV_ESTAB_OUT <= !(HASH_FINISH_IN && estab_reg) && (clear_estab || estab_reg);
        end
    end

    // ****************************************
    // command status state machine
    // ****************************************
    lrs_pkg::lrs_state_t state_reg;
    lrs_pkg::lrs_state_t state_next;
    logic [lrs_pkg::CNT_W-1:0] exec_cnt_reg;
    logic resp_avail_reg;
    logic from_active;
    logic ready_wr;
    logic exec_wr;
    logic fifo_wr;
    logic loc_change;
    logic exec_done;

    assign from_active = active_valid_reg && (wreq.loc == active_loc_reg);
    assign ready_wr = sts_ok && from_active && wreq.data[lrs_pkg::STS_CMD_READY];
    assign exec_wr = sts_ok && from_active && wreq.data[lrs_pkg::STS_EXECUTE];
    assign fifo_wr = wreq.fifo_wr && from_active;
    assign loc_change = grant_now || rel_by_active;
    assign exec_done = (32'(exec_cnt_reg) >= EXEC_CYC - 1);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lrs_pkg::LRS_IDLE: begin
                if (ready_wr) begin
                    state_next = lrs_pkg::LRS_READY;
                end
            end
            lrs_pkg::LRS_READY: begin
                if (fifo_wr) begin
                    state_next = lrs_pkg::LRS_RECEIVE;
                end
            end
            lrs_pkg::LRS_RECEIVE: begin
                if (exec_wr) begin
                    state_next = lrs_pkg::LRS_EXECUTE;
                end else if (ready_wr) begin
                    state_next = lrs_pkg::LRS_IDLE;
                end
            end
            lrs_pkg::LRS_EXECUTE: begin
                if (ready_wr) begin
                    state_next = lrs_pkg::LRS_IDLE;
                end else if (exec_done) begin
                    state_next = lrs_pkg::LRS_COMPLETE;
                end
            end
            lrs_pkg::LRS_COMPLETE: begin
                if (ready_wr) begin
                    state_next = lrs_pkg::LRS_READY;
                end
            end
        endcase
        if (loc_change) begin
            state_next = lrs_pkg::LRS_IDLE;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_reg <= lrs_pkg::LRS_IDLE;
        end else if (INIT_IN) begin
            state_reg <= lrs_pkg::LRS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // execution is modelled as a fixed latency; the real engine sits elsewhere
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            exec_cnt_reg <= '0;
        end else if (state_reg != lrs_pkg::LRS_EXECUTE) begin
            exec_cnt_reg <= '0;
        end else if (!exec_done) begin
            exec_cnt_reg <= exec_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            resp_avail_reg <= 1'b0;
        end else begin
            resp_avail_reg <= (state_next == lrs_pkg::LRS_COMPLETE);
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            RDATA_OUT <= '0;
        end else if (RD_IN && rd_loc_ok && ADDR_IN[11:0] == lrs_pkg::OFF_ACCESS) begin
            RDATA_OUT <= '0;
            RDATA_OUT[lrs_pkg::ACC_VALID] <= estab_loaded_reg;
            RDATA_OUT[lrs_pkg::ACC_GRANTED] <= active_valid_reg && (active_loc_reg == rd_loc);
            RDATA_OUT[lrs_pkg::ACC_WAITING] <= waiting_reg[rd_loc];
            RDATA_OUT[lrs_pkg::ACC_REQUEST] <= request_reg[rd_loc];
            RDATA_OUT[lrs_pkg::ACC_ESTAB] <= estab_reg && estab_loaded_reg;
        end else if (RD_IN && rd_loc_ok && ADDR_IN[11:0] == lrs_pkg::OFF_STATUS) begin
            RDATA_OUT <= '0;
            RDATA_OUT[lrs_pkg::STS_STS_VALID] <= 1'b1;
            RDATA_OUT[lrs_pkg::STS_CMD_READY] <= (state_reg == lrs_pkg::LRS_READY);
            RDATA_OUT[lrs_pkg::STS_RESP_AVAIL] <= resp_avail_reg;
        end else begin
            RDATA_OUT <= '0;
        end
    end

    assign ACTIVE_LOC_OUT = active_loc_reg;
    assign ACTIVE_VALID_OUT = active_valid_reg;
    assign STATE_OUT = state_reg;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_exec_start;
        state_reg == lrs_pkg::LRS_RECEIVE && exec_wr && !loc_change;
    endsequence

    a_request_set: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        acc_req_wr && !INIT_IN && !request_reg[wreq.loc] && !from_active |=> request_reg[$past(wreq.loc)])
        else $error("request flag not set");
    a_zero_keeps: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        wreq.access_wr && wreq.data == '0 && !grant_now && !INIT_IN |=> request_reg == $past(request_reg))
        else $error("zero write changed request");
    a_grant_clears: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        grant_now && !INIT_IN |=> active_valid_reg && !request_reg[active_loc_reg])
        else $error("grant left request set");
    a_grant_timely: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN || INIT_IN)
        !active_valid_reg && |request_reg |=> active_valid_reg)
        else $error("free device did not grant");
    a_waiting_others: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        acc_req_wr && !request_reg[wreq.loc] && !from_active && !INIT_IN
        |=> (waiting_reg | $past(wr_loc_onehot)) == {NUM_LOC{1'b1}})
        else $error("waiting indication missing");
    a_estab_hold: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        estab_loaded_reg && !estab_reg && !clear_estab |=> !estab_reg)
        else $error("established flag rose without clear");
    a_bad_sts_ignored: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        wreq.status_wr && !sts_ok && !loc_change && !INIT_IN && state_reg != lrs_pkg::LRS_EXECUTE
        |=> state_reg == $past(state_reg))
        else $error("multi-field status write acted");
    a_exec_enter: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN || INIT_IN)
        s_exec_start |=> state_reg == lrs_pkg::LRS_EXECUTE ##[1:300] state_reg != lrs_pkg::LRS_EXECUTE)
        else $error("execution did not start or end");
    a_ready_reads: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        RD_IN && rd_loc_ok && ADDR_IN[11:0] == lrs_pkg::OFF_STATUS && state_reg == lrs_pkg::LRS_READY
        |=> RDATA_OUT[lrs_pkg::STS_CMD_READY])
        else $error("ready not reported");
    a_init_idle: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
        INIT_IN |=> state_reg == lrs_pkg::LRS_IDLE)
        else $error("init did not force idle");

endmodule : lrs_locality_status

//--- verification/lrs_nv_cell.sv
// lrs_nv_cell: behavioural nonvolatile cell that holds the launch established flag.
// assumes the block writes it with a one-cycle strobe on the rising clock edge.
`timescale 1ns/1ps
module lrs_nv_cell (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic write_in,
    input wire logic estab_in,
    output logic estab_out,
    output logic valid_out
);
    // ****************************************
    // stored value and wake-up delay
    // ****************************************
    logic cell_reg = 1'b1;
    logic [1:0] wake_reg = 2'h0;
    // no reset on the cell: the value must outlive power and reset cycles
    always @(posedge clk_in) begin
        if (write_in) begin
            cell_reg <= estab_in;
        end
    end
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_reg <= 2'h0;
        end else if (wake_reg != 2'h3) begin
            wake_reg <= wake_reg + 2'h1;
        end
    end
    assign valid_out = (wake_reg == 2'h3);
    // not yet awake: show the inverse so a stale value cannot pass for the real one
    assign estab_out = valid_out ? cell_reg : ~cell_reg;
endmodule : lrs_nv_cell

//--- verification/testbench.sv
// testbench: drives the register port of lrs_locality_status and judges what it returns.
// assumes the nonvolatile cell model stands on the established flag side.
`timescale 1ns/1ps
module testbench;
    localparam int EXEC_N = 4;
    localparam logic [11:0] ACC = lrs_pkg::OFF_ACCESS;
    localparam logic [11:0] STS = lrs_pkg::OFF_STATUS;
    localparam logic [11:0] FIFO = lrs_pkg::OFF_FIFO;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic init = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic hash = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic nv_wr, nv_q, nv_e, nv_v, act_v;
    logic [2:0] act_loc;
    lrs_pkg::lrs_state_t state;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    lrs_locality_status #(.EXEC_CYC(EXEC_N)) i_dut (.CLOCK_IN(clk), .RESET_IN(rst), .INIT_IN(init),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .HASH_FINISH_IN(hash), .NV_ESTAB_IN(nv_q), .NV_VALID_IN(nv_v), .NV_WRITE_OUT(nv_wr),
        .NV_ESTAB_OUT(nv_e), .ACTIVE_LOC_OUT(act_loc), .ACTIVE_VALID_OUT(act_v), .STATE_OUT(state));
    lrs_nv_cell i_nv (.clk_in(clk), .rst_in(rst), .write_in(nv_wr), .estab_in(nv_e),
        .estab_out(nv_q), .valid_out(nv_v));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // bus cycles and compares
    // ****************************************
    task automatic wr_reg(input logic [2:0] loc, input logic [11:0] off, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= {1'b0, loc, off};
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] loc, input logic [11:0] off);
        @(posedge clk);
        rd <= 1'b1;
        addr <= {1'b0, loc, off};
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_st(input lrs_pkg::lrs_state_t exp);
        #1 cmp({29'h0, state}, {29'h0, exp});
    endtask : cmp_st
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_grant();
        wr_reg(3'h1, ACC, 32'h2);
        d = 32'h0;
        for (int i = 0; i < 8 && d[5] !== 1'b1; i++) begin
            rd_reg(3'h1, ACC);
        end
        cmp(d & 32'h22, 32'h20);
        rd_reg(3'h0, ACC);
        cmp(d & 32'h22, 32'h0);
        wr_reg(3'h3, ACC, 32'h2);
        wr_reg(3'h3, ACC, 32'h2);
        wr_reg(3'h3, ACC, 32'h0);
        rd_reg(3'h3, ACC);
        cmp(d & 32'h22, 32'h2);
        rd_reg(3'h0, ACC);
        cmp(d & 32'h4, 32'h4);
        wr_reg(3'h3, ACC, 32'h20);
        rd_reg(3'h3, ACC);
        cmp(d & 32'h22, 32'h0);
        rd_reg(3'h1, 12'h100);
        cmp(d, 32'h0);
    endtask : t_grant
    task automatic t_status();
        wr_reg(3'h1, STS, 32'h40);
        rd_reg(3'h1, STS);
        cmp(d & 32'hc0, 32'hc0);
        wr_reg(3'h1, STS, 32'h60);
        cmp_st(lrs_pkg::LRS_READY);
        wr_reg(3'h1, STS, 32'h0);
        wr_reg(3'h0, FIFO, 32'h80);
        cmp_st(lrs_pkg::LRS_READY);
        wr_reg(3'h1, FIFO, 32'h80);
        cmp_st(lrs_pkg::LRS_RECEIVE);
        wr_reg(3'h1, STS, 32'h20);
        cmp_st(lrs_pkg::LRS_EXECUTE);
        for (int i = 0; i < EXEC_N + 4 && state !== lrs_pkg::LRS_COMPLETE; i++) begin
            @(posedge clk);
        end
        cmp_st(lrs_pkg::LRS_COMPLETE);
        rd_reg(3'h1, STS);
        cmp(d & 32'h50, 32'h10);
        wr_reg(3'h1, STS, 32'h40);
        cmp_st(lrs_pkg::LRS_READY);
        wr_reg(3'h1, STS, 32'h40);
        cmp_st(lrs_pkg::LRS_READY);
        wr_reg(3'h1, FIFO, 32'h80);
        wr_reg(3'h1, STS, 32'h20);
        wr_reg(3'h1, STS, 32'h40);
        cmp_st(lrs_pkg::LRS_IDLE);
    endtask : t_status
    task automatic t_estab();
        rd_reg(3'h0, ACC);
        cmp(d & 32'h81, 32'h81);
        @(posedge clk);
        hash <= 1'b1;
        @(posedge clk);
        hash <= 1'b0;
        rd_reg(3'h4, ACC);
        cmp(d & 32'h1, 32'h0);
        wr_reg(3'h1, STS, 32'h0200_0000);
        rd_reg(3'h0, ACC);
        cmp(d & 32'h1, 32'h0);
    endtask : t_estab
    task automatic t_reset_init();
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(3'h0, ACC);
        cmp(d & 32'h81, 32'h0);
        repeat (6) @(posedge clk);
        rd_reg(3'h2, ACC);
        cmp(d & 32'h81, 32'h80);
        cmp_st(lrs_pkg::LRS_IDLE);
        wr_reg(3'h4, ACC, 32'h2);
        repeat (2) @(posedge clk);
        cmp({28'h0, act_v, act_loc}, 32'hc);
        wr_reg(3'h4, STS, 32'h0200_0000);
        rd_reg(3'h4, ACC);
        cmp(d & 32'h1, 32'h1);
        wr_reg(3'h4, STS, 32'h40);
        @(posedge clk);
        init <= 1'b1;
        @(posedge clk);
        init <= 1'b0;
        cmp_st(lrs_pkg::LRS_IDLE);
        cmp({31'h0, act_v}, 32'h0);
    endtask : t_reset_init
    // ****************************************
    // run control
    // ****************************************
    task automatic close_out();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // a hang in any wait ends the run as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_grant();
        t_status();
        t_estab();
        t_reset_init();
        close_out();
    end
endmodule : testbench
